/* File: core/rvc_pkg.sv */
// rvc_pkg: constants shared by the retract velocity control block.
// assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.
package rvc_pkg;
    // clock and power-on hold timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned HOLD_MS = 120;
    localparam int unsigned HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);
    // cylinder address width and speed step count
    localparam int CYL_W = 9;
    localparam int STEP_N = 7;
    localparam logic [CYL_W-1:0] CYL_RST = 9'h000;
    // register byte offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_TARGET = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CURRENT = 4'hC;
    // control register bits (write one, self clearing)
    localparam int CTRL_RESTORE = 0;
    localparam int CTRL_RELEASE = 1;
    // status register bits
    localparam int ST_HOMING = 0;
    localparam int ST_LATCH_A = 1;
    localparam int ST_LATCH_B = 2;
    localparam int ST_SEEK_OK = 3;
    localparam int ST_REVERSE = 4;
    localparam int ST_HOLD = 5;
    localparam int ST_OP_LSB = 8;
    localparam int OP_W = 4;
    // carriage operation, one-hot
    typedef enum logic [OP_W-1:0] {
        OP_IDLE = 4'h1,
        OP_PRELOAD = 4'h2,
        OP_RESTORE = 4'h4,
        OP_RETRACT = 4'h8
    } rvc_op_type;
endpackage : rvc_pkg

/* File: core/rvc_ctl_if.sv */
// rvc_ctl_if: register-side pulses and block status between core and slave.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface rvc_ctl_if;
    import rvc_pkg::*;
    logic restore_wr;
    logic release_wr;
    logic tgt_wr;
    logic [CYL_W-1:0] tgt_wdata;
    logic [31:0] status;
    logic [CYL_W-1:0] target;
    logic [CYL_W-1:0] current;
    modport slave (
        output restore_wr, release_wr, tgt_wr, tgt_wdata,
        input status, target, current
    );
    modport core (
        input restore_wr, release_wr, tgt_wr, tgt_wdata,
        output status, target, current
    );
endinterface : rvc_ctl_if
`default_nettype wire

/* File: core/rvc_hold_timer.sv */
// rvc_hold_timer: power-on hold, low for HOLD_CYCLES after reset release.
// assumes sys_rst marks first power application.
`timescale 1ns/10ps
`default_nettype none
module rvc_hold_timer #(
    parameter int unsigned HOLD_CYCLES = rvc_pkg::HOLD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // hold output
    output logic hold_n
);
    import rvc_pkg::*;
    initial begin
        if (HOLD_CYCLES < 1) $error("rvc_hold_timer: HOLD_CYCLES must be at least 1");
    end
    logic [31:0] cnt_q, cnt_d;
    logic hold_q, hold_d;
    always_comb begin
        cnt_d = cnt_q;
        hold_d = hold_q;
        if (hold_q) begin
            if (cnt_q == HOLD_CYCLES - 1) hold_d = 1'b0;
            else cnt_d = cnt_q + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 32'h0000_0000;
            hold_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            hold_q <= hold_d;
        end
    end
    assign hold_n = ~hold_q;
endmodule : rvc_hold_timer
`default_nettype wire

/* File: core/rvc_avmm_slave.sv */
// rvc_avmm_slave: Avalon-MM slave with one wait state for the control registers.
// assumes the master holds its request until waitrequest is seen low.
`timescale 1ns/10ps
`default_nettype none
module rvc_avmm_slave (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm
    input wire logic [rvc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // core side
    rvc_ctl_if.slave ctl
);
    import rvc_pkg::*;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic req;
    logic wr_go;
    assign req = avs_read | avs_write;
    // the answer lands one cycle after the request so read data is already registered
    assign avs_waitrequest = req & ~ack_q;
    assign wr_go = avs_write & ack_q & avs_byteenable[0];
    always_comb begin
        ack_d = req & ~ack_q;
        rdata_d = rdata_q;
        if (avs_read && !ack_q) begin
            case (avs_address)
                REG_STATUS: rdata_d = ctl.status;
                REG_TARGET: rdata_d = {{(32-CYL_W){1'b0}}, ctl.target};
                REG_CURRENT: rdata_d = {{(32-CYL_W){1'b0}}, ctl.current};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end
    assign avs_readdata = rdata_q;
    assign ctl.restore_wr = wr_go && avs_address == REG_CTRL && avs_writedata[CTRL_RESTORE];
    assign ctl.release_wr = wr_go && avs_address == REG_CTRL && avs_writedata[CTRL_RELEASE];
    // target needs both low lanes since it is nine bits wide
    assign ctl.tgt_wr = wr_go && avs_byteenable[1] && avs_address == REG_TARGET;
    assign ctl.tgt_wdata = avs_writedata[CYL_W-1:0];
endmodule : rvc_avmm_slave
`default_nettype wire

/* File: core/rvc_core.sv */
// rvc_core: homing/retract velocity request for the cylinder addressing logic.
// assumes all drive-side inputs are synchronous to clk and sys_rst is power-up.
// Notes on behaviour
// - spindle-at-speed rising edge force-sets latch A, starting preload head advance.
// - a restore command sets latch A, raising the homing request.
// - power-on hold is low about 120 ms after power-up and raises homing.
// - spindle lost while heads not parked raises homing and starts retract.
// - while homing, the speed decode issues the minimum speed command.
// - while homing, all seven higher speed steps 1 to 7 are suppressed.
// - homing sets latch B, forcing target zero and dropping seek permitted.
// - while target-zero force is high, target register data inputs are zero.
// - during preload, homing steers the direction select to forward.
// - while homing, target register clocking is blocked and current counter cleared.
// - seek permitted needs latch B clear, seek latch clear, ready, no incomplete.
// - direction reads reverse if hold, reverse seek, restore or retract is active.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rvc_core #(
    parameter int unsigned HOLD_CYCLES = rvc_pkg::HOLD_CYCLES,
    parameter int CYL_W = rvc_pkg::CYL_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm register port
    input wire logic [rvc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // drive status inputs
    input wire logic spindle_at_speed,
    input wire logic heads_parked,
    input wire logic drive_ready,
    input wire logic seek_latch,
    input wire logic seek_incomplete,
    // controller commands
    input wire logic restore_req,
    input wire logic addr_strobe,
    input wire logic [CYL_W-1:0] addr_in,
    // seek arithmetic and carriage feedback
    input wire logic subtract_carry,
    input wire logic diff_zero,
    input wire logic [2:0] speed_code,
    input wire logic track_step,
    input wire logic home_done,
    // servo commands
    output logic homing_req,
    output logic min_speed,
    output logic [rvc_pkg::STEP_N-1:0] speed_step,
    output logic motion_reverse,
    // address logic
    output logic target_zero,
    output logic seek_permitted,
    output logic [CYL_W-1:0] target_cyl,
    output logic [CYL_W-1:0] current_cyl,
    output logic power_hold_n
);
    import rvc_pkg::*;

    initial begin
        if (CYL_W < 1 || CYL_W > 16) $error("rvc_core: CYL_W out of range");
        if (CYL_W != rvc_pkg::CYL_W) $error("rvc_core: CYL_W must match the package");
    end

    rvc_ctl_if ctl ();

    rvc_avmm_slave u_slave (
        .clk(clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .ctl(ctl.slave)
    );

    rvc_hold_timer #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_hold (
        .clk(clk),
        .sys_rst(sys_rst),
        .hold_n(power_hold_n)
    );

    // ------------------------------------------------------------
    // spindle edge detect and retract condition
    // ------------------------------------------------------------
    logic spin_q, spin_d;
    logic spin_rise;
    logic retract_cond;
    logic hold_act;

    always_comb begin
        spin_d = spindle_at_speed;
    end

    always_ff @(posedge clk) begin
        // reset high: a spindle already at speed at power-up is not a rising edge
        if (sys_rst) begin
            spin_q <= 1'b1;
        end else begin
            spin_q <= spin_d;
        end
    end

    assign spin_rise = spindle_at_speed & ~spin_q;
    // a level, so retract keeps pulling until the heads report parked
    assign retract_cond = ~spindle_at_speed & ~heads_parked;
    assign hold_act = ~power_hold_n;

    // ------------------------------------------------------------
    // carriage latches
    // ------------------------------------------------------------
    logic latch_a_q, latch_a_d;
    logic latch_b_q, latch_b_d;
    logic restore_any;

    assign restore_any = restore_req | ctl.restore_wr;

    always_comb begin
        latch_a_d = latch_a_q;
        latch_b_d = latch_b_q;
        // clear first so a set in the same cycle wins
        if (home_done) begin
            latch_a_d = 1'b0;
        end
        if (spin_rise) begin
            latch_a_d = 1'b1;
        end
        if (restore_any) begin
            latch_a_d = 1'b1;
        end
        // latch B stays set until software releases it after homing ends
        if (ctl.release_wr && !homing_req) begin
            latch_b_d = 1'b0;
        end
        if (homing_req) begin
            latch_b_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_a_q <= 1'b0;
            latch_b_q <= 1'b0;
        end else begin
            latch_a_q <= latch_a_d;
            latch_b_q <= latch_b_d;
        end
    end

    assign homing_req = latch_a_q | hold_act | retract_cond;
    assign target_zero = latch_b_q;
    assign seek_permitted = ~latch_b_q & ~seek_latch & drive_ready & ~seek_incomplete;

    // ------------------------------------------------------------
    // speed decode
    // ------------------------------------------------------------
    always_comb begin
        min_speed = homing_req | (speed_code == 3'h0);
        for (int k = 0; k < STEP_N; k++) begin
            // homing suppresses every step so only minimum speed reaches the servo
            speed_step[k] = ~homing_req && (speed_code == 3'(k + 1));
        end
    end

    // ------------------------------------------------------------
    // direction select
    // ------------------------------------------------------------
    logic rev_seek;
    logic restore_cond;

    // homing (with interlock) turns the subtractor term to forward during preload
    assign rev_seek = subtract_carry & ~homing_req & ~diff_zero;
    // latch A over the tracks is a restore; over the parked stop it is preload
    assign restore_cond = latch_a_q & ~heads_parked;
    assign motion_reverse = hold_act | rev_seek | restore_cond | retract_cond;

    // ------------------------------------------------------------
    // target cylinder register
    // ------------------------------------------------------------
    logic [CYL_W-1:0] tgt_q, tgt_d;
    logic tgt_load;
    logic [CYL_W-1:0] tgt_in;

    always_comb begin
        tgt_load = (addr_strobe | ctl.tgt_wr) & ~homing_req;
        tgt_in = ctl.tgt_wr ? ctl.tgt_wdata : addr_in;
        tgt_d = tgt_q;
        if (tgt_load) begin
            tgt_d = target_zero ? CYL_RST : tgt_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tgt_q <= CYL_RST;
        end else begin
            tgt_q <= tgt_d;
        end
    end

    assign target_cyl = tgt_q;

    // ------------------------------------------------------------
    // current cylinder counter
    // ------------------------------------------------------------
    logic [CYL_W-1:0] cur_q, cur_d;

    always_comb begin
        cur_d = cur_q;
        if (homing_req) begin
            cur_d = CYL_RST;
        end else if (track_step) begin
            if (motion_reverse) cur_d = cur_q - CYL_W'(1);
            else cur_d = cur_q + CYL_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_q <= CYL_RST;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign current_cyl = cur_q;

    // ------------------------------------------------------------
    // carriage operation tracker, reported in status
    // ------------------------------------------------------------
    rvc_op_type op_q, op_d;

    always_comb begin
        op_d = op_q;
        case (op_q)
            OP_IDLE: begin
                if (retract_cond) op_d = OP_RETRACT;
                else if (latch_a_q && heads_parked) op_d = OP_PRELOAD;
                else if (latch_a_q) op_d = OP_RESTORE;
            end
            OP_PRELOAD: begin
                if (retract_cond) op_d = OP_RETRACT;
                else if (!latch_a_q) op_d = OP_IDLE;
            end
            OP_RESTORE: begin
                if (retract_cond) op_d = OP_RETRACT;
                else if (!latch_a_q) op_d = OP_IDLE;
            end
            OP_RETRACT: begin
                if (!retract_cond) op_d = OP_IDLE;
            end
            default: op_d = OP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_q <= OP_IDLE;
        end else begin
            op_q <= op_d;
        end
    end

    // ------------------------------------------------------------
    // register view
    // ------------------------------------------------------------
    always_comb begin
        ctl.status = 32'h0000_0000;
        ctl.status[ST_HOMING] = homing_req;
        ctl.status[ST_LATCH_A] = latch_a_q;
        ctl.status[ST_LATCH_B] = latch_b_q;
        ctl.status[ST_SEEK_OK] = seek_permitted;
        ctl.status[ST_REVERSE] = motion_reverse;
        ctl.status[ST_HOLD] = hold_act;
        ctl.status[ST_OP_LSB +: OP_W] = op_q;
    end

    assign ctl.target = tgt_q;
    assign ctl.current = cur_q;

endmodule : rvc_core
`default_nettype wire

/* File: bench/rvc_core_asserts.sv */
// rvc_core_asserts: port-level checks on rvc_core.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module rvc_core_asserts #(
    parameter int unsigned HOLD_CYCLES = rvc_pkg::HOLD_CYCLES,
    parameter int CYL_W = rvc_pkg::CYL_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // drive side
    input wire logic spindle_at_speed,
    input wire logic heads_parked,
    input wire logic drive_ready,
    input wire logic seek_latch,
    input wire logic seek_incomplete,
    input wire logic restore_req,
    // outputs
    input wire logic homing_req,
    input wire logic min_speed,
    input wire logic [rvc_pkg::STEP_N-1:0] speed_step,
    input wire logic motion_reverse,
    input wire logic target_zero,
    input wire logic seek_permitted,
    input wire logic [CYL_W-1:0] target_cyl,
    input wire logic [CYL_W-1:0] current_cyl,
    input wire logic power_hold_n
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    // saturates just past the hold so the count never wraps
    always_comb begin
        cnt_d = (cnt_q < HOLD_CYCLES + 2) ? cnt_q + 32'h1 : cnt_q;
    end
    always_ff @(posedge clk) begin
        cnt_q <= sys_rst ? 32'h0 : cnt_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_min; homing_req |-> min_speed; endproperty
    a_min: assert property (p_min) else $error("no minimum speed");
    property p_step; homing_req |-> speed_step == 7'h00; endproperty
    a_step: assert property (p_step) else $error("speed step while homing");
    property p_latb; homing_req |=> target_zero; endproperty
    a_latb: assert property (p_latb) else $error("target zero not set");
    property p_seek; seek_permitted == (!target_zero && !seek_latch && drive_ready
        && !seek_incomplete); endproperty
    a_seek: assert property (p_seek) else $error("seek permitted wrong");
    property p_rest; restore_req |=> homing_req; endproperty
    a_rest: assert property (p_rest) else $error("restore not homing");
    property p_spin; $rose(spindle_at_speed) |-> ##[1:2] homing_req; endproperty
    a_spin: assert property (p_spin) else $error("no preload homing");
    property p_ret; !spindle_at_speed && !heads_parked |-> homing_req && motion_reverse;
    endproperty
    a_ret: assert property (p_ret) else $error("retract missing");
    property p_hold; !power_hold_n |-> homing_req && motion_reverse; endproperty
    a_hold: assert property (p_hold) else $error("hold not homing");
    property p_cur; homing_req |=> current_cyl == '0; endproperty
    a_cur: assert property (p_cur) else $error("current not cleared");
    property p_tgt; homing_req |=> $stable(target_cyl); endproperty
    a_tgt: assert property (p_tgt) else $error("target clocked while homing");
    property p_hlen; cnt_q + 32'h1 < HOLD_CYCLES |-> !power_hold_n; endproperty
    a_hlen: assert property (p_hlen) else $error("hold too short");
    property p_hend; cnt_q > HOLD_CYCLES |-> power_hold_n; endproperty
    a_hend: assert property (p_hend) else $error("hold too long");
endmodule : rvc_core_asserts
`default_nettype wire

/* File: bench/rvc_ctl_model.sv */
// rvc_ctl_model: disk controller issuing restore and seek commands.
// assumes the bench calls its tasks from one process at a time.
`timescale 1ns/10ps
`default_nettype none
module rvc_ctl_model #(
    parameter int CYL_W = 9
) (
    // clock
    input wire logic clk,
    // commands
    output logic restore_req,
    output logic addr_strobe,
    output logic [CYL_W-1:0] addr_in
);
    logic busy = 1'b0;
    initial begin
        restore_req = 1'b0;
        addr_strobe = 1'b0;
        addr_in = '0;
    end
    // address lines mean nothing outside a strobe, so keep them moving
    always @(posedge clk) begin
        if (!busy) begin
            addr_in <= ~addr_in;
        end
    end
    task automatic seek(input logic [CYL_W-1:0] cyl);
        busy = 1'b1;
        @(posedge clk);
        addr_in <= cyl;
        addr_strobe <= 1'b1;
        @(posedge clk);
        addr_strobe <= 1'b0;
        @(negedge clk);
        busy = 1'b0;
    endtask : seek
    task automatic restore();
        @(posedge clk);
        restore_req <= 1'b1;
        @(posedge clk);
        restore_req <= 1'b0;
    endtask : restore
endmodule : rvc_ctl_model
`default_nettype wire

/* File: bench/tb_retract_velocity_control.sv */
// tb_retract_velocity_control: directed tests of rvc_core at its ports.
// assumes the controller model and the checker bound below.
`timescale 1ns/10ps
`default_nettype none
module tb_retract_velocity_control;
    import rvc_pkg::*;
    localparam int unsigned HOLD = 20;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic spindle_at_speed = 1'b1;
    logic heads_parked = 1'b1;
    logic drive_ready = 1'b1;
    logic seek_latch = 1'b0;
    logic seek_incomplete = 1'b0;
    logic subtract_carry = 1'b0;
    logic diff_zero = 1'b0;
    logic [2:0] speed_code = 3'h0;
    logic track_step = 1'b0;
    logic home_done = 1'b0;
    logic restore_req, addr_strobe, homing_req, min_speed, motion_reverse;
    logic target_zero, seek_permitted, power_hold_n;
    logic [CYL_W-1:0] addr_in, target_cyl, current_cyl;
    logic [STEP_N-1:0] speed_step;
    logic [31:0] rd;
    logic [2:0] bad_set [3] = '{3'h0, 3'h6, 3'h5};
    int bad_count = 0;
    int checks = 0;
    rvc_core #(.HOLD_CYCLES(HOLD)) dut (.clk, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .spindle_at_speed, .heads_parked, .drive_ready, .seek_latch, .seek_incomplete,
        .restore_req, .addr_strobe, .addr_in, .subtract_carry, .diff_zero, .speed_code,
        .track_step, .home_done, .homing_req, .min_speed, .speed_step, .motion_reverse,
        .target_zero, .seek_permitted, .target_cyl, .current_cyl, .power_hold_n);
    rvc_ctl_model ctl (.clk, .restore_req, .addr_strobe, .addr_in);
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    initial begin
        #(50 * 4000);
        bad_count++;
        results();
    end
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    // one request held until waitrequest is seen low, then released
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        // waitrequest is seen at the edge itself, before that edge's updates land
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic steps(input int n);
        repeat (n) begin
            @(posedge clk) track_step <= 1'b1;
            @(posedge clk) track_step <= 1'b0;
        end
    endtask : steps
    task automatic done_pulse();
        @(posedge clk) home_done <= 1'b1;
        @(posedge clk) home_done <= 1'b0;
    endtask : done_pulse
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(1);
        chk_bit(power_hold_n, 1'b0);
        chk_bit(homing_req, 1'b1);
        chk_bit(motion_reverse, 1'b1);
        cyc(HOLD);
        chk_bit(power_hold_n, 1'b1);
        chk_bit(homing_req, 1'b0);
        chk_bit(target_zero, 1'b1);
        bus(1'b1, REG_CTRL, 32'h2);
        bus(1'b0, 4'h2, 32'h0);
        chk_word(rd, 32'h0);
        cyc(0);
        chk_bit(seek_permitted, 1'b1);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) {drive_ready, seek_latch, seek_incomplete} <= bad_set[i];
            cyc(0);
            chk_bit(seek_permitted, 1'b0);
        end
        @(posedge clk) {drive_ready, seek_latch, seek_incomplete} <= 3'h4;
        ctl.seek(9'h05A);
        cyc(1);
        chk_word({23'h0, target_cyl}, 32'h5A);
        for (int k = 1; k < 8; k++) begin
            @(posedge clk) speed_code <= k[2:0];
            cyc(0);
            chk_word({25'h0, speed_step}, 32'h1 << (k - 1));
            chk_bit(min_speed, 1'b0);
        end
        steps(3);
        @(posedge clk) subtract_carry <= 1'b1;
        cyc(0);
        chk_bit(motion_reverse, 1'b1);
        steps(4);
        bus(1'b0, REG_CURRENT, 32'h0);
        chk_word(rd, 32'h1FF);
        bus(1'b1, REG_TARGET, 32'h0A5);
        bus(1'b0, REG_TARGET, 32'h0);
        chk_word(rd, 32'hA5);
        @(posedge clk) diff_zero <= 1'b1;
        heads_parked <= 1'b0;
        ctl.restore();
        cyc(0);
        chk_bit(homing_req, 1'b1);
        chk_bit(min_speed, 1'b1);
        chk_word({25'h0, speed_step}, 32'h0);
        chk_bit(motion_reverse, 1'b1);
        cyc(1);
        chk_bit(target_zero, 1'b1);
        chk_bit(seek_permitted, 1'b0);
        chk_word({23'h0, current_cyl}, 32'h0);
        ctl.seek(9'h033);
        cyc(1);
        chk_word({23'h0, target_cyl}, 32'hA5);
        done_pulse();
        ctl.seek(9'h033);
        cyc(1);
        chk_word({23'h0, target_cyl}, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk_word(rd, 32'h104);
        bus(1'b1, REG_CTRL, 32'h2);
        @(posedge clk) heads_parked <= 1'b1;
        spindle_at_speed <= 1'b0;
        diff_zero <= 1'b0;
        cyc(2);
        chk_bit(homing_req, 1'b0);
        @(posedge clk) spindle_at_speed <= 1'b1;
        cyc(3);
        chk_bit(homing_req, 1'b1);
        chk_bit(motion_reverse, 1'b0);
        done_pulse();
        cyc(0);
        chk_bit(homing_req, 1'b0);
        bus(1'b1, REG_CTRL, 32'h1);
        cyc(0);
        chk_bit(homing_req, 1'b1);
        done_pulse();
        @(posedge clk) heads_parked <= 1'b0;
        spindle_at_speed <= 1'b0;
        cyc(1);
        chk_bit(homing_req, 1'b1);
        chk_bit(motion_reverse, 1'b1);
        results();
    end
endmodule : tb_retract_velocity_control
bind rvc_core rvc_core_asserts #(.HOLD_CYCLES(HOLD_CYCLES), .CYL_W(CYL_W)) u_chk (
    .clk, .sys_rst, .spindle_at_speed, .heads_parked, .drive_ready, .seek_latch,
    .seek_incomplete, .restore_req, .homing_req, .min_speed, .speed_step, .motion_reverse,
    .target_zero, .seek_permitted, .target_cyl, .current_cyl, .power_hold_n);
`default_nettype wire
